// ==== include/safing_pkg.sv ====
// Constants shared by the safing engine and its dwell stretch counters
package safing_pkg;
  localparam int          NUM_RECORDS     = 4;
  localparam int          CNT_W           = 8;
  localparam int          DWELL_W         = 4;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          TICK_US         = 1;
  localparam int          TICK_CYCLES     = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int          DWELL_UNIT_US   = 1000;
  localparam int          SCRAP_TIMEOUT_US = 100000;
  localparam int          DISP_PERIOD_MIN_US = 200;
  localparam int          DISP_PERIOD_MAX_US = 300;
  localparam int          DISP_HIGH_MIN_US   = 80;
  localparam int          DISP_HIGH_MAX_US   = 120;
  localparam int          DISP_GOOD_NEEDED   = 3;
  localparam int          DISP_BAD_LIMIT     = 2;
  // Register byte offsets
  localparam logic [7:0]  OFS_GLOBAL      = 8'h00;
  localparam logic [7:0]  OFS_PERMIT_TH   = 8'h04;
  localparam logic [7:0]  OFS_LOOP_MASK   = 8'h08;
  localparam logic [7:0]  OFS_COMPLETE    = 8'h0c;
  localparam logic [7:0]  OFS_ENABLE      = 8'h10;
  localparam logic [7:0]  OFS_STATUS      = 8'h14;
  localparam logic [7:0]  OFS_REC_CTRL    = 8'h20;
  localparam logic [7:0]  OFS_REC_COUNT   = 8'h30;
  // Global register fields
  localparam int          GL_INC_LSB      = 0;
  localparam int          GL_DEC_LSB      = 8;
  localparam int          GL_EXT_ENGINE   = 16;
  localparam int          GL_EXT_RAIL     = 17;
  localparam int          GL_TEST_PIN     = 18;
  localparam int          GL_TEST_RAIL    = 19;
  // Record control word fields
  localparam int          RC_MAP          = 16;
  localparam int          RC_DWELL_LSB    = 17;
  localparam int          RC_COMBINE      = 21;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  localparam logic [31:0] RST_GLOBAL      = 32'h0000_0101;
  localparam logic [31:0] RST_PERMIT_TH   = 32'h0000_0404;
  localparam logic [7:0]  RST_LOOP_MASK   = 8'hff;

  typedef enum logic [0:0] {
    SCRAP_IDLE   = 1'b0,
    SCRAP_ARMING = 1'b1
  } scrap_state_t;
endpackage

// ==== logic/dwell_stretch.sv ====
// Dwell stretch counter that only ever extends its remaining time
`timescale 1ns/1ps
`default_nettype none
module dwell_stretch #(
  parameter int W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_clear,
  input  wire logic         i_tick,
  input  wire logic         i_arm,
  input  wire logic [W-1:0] i_value,
  output logic              o_active
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      cnt_q <= '0;
    end else if (i_arm && (cnt_q < i_value)) begin
      cnt_q <= i_value;
    end else if (i_tick && (cnt_q != '0)) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // Runs on regardless of the arm source going away
  assign o_active = i_arm || (cnt_q != '0);
endmodule
`default_nettype wire

// ==== logic/safing_engine.sv ====
// Safing engine: sample judging, event counters, permits, dwell and scrap arming
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Record settings and engine selection change only in diagnostic state; enables anytime.
// - Safing sequencer reset holds records, counters, permits and dwell counters inactive.
// - Four records, each with its own control word, sharing one global configuration.
// - Signed sample above threshold is positive event, below negated threshold negative.
// - Triggered counter adds count_increment, otherwise subtracts count_decrement.
// - Separate positive and negative counters, both updated on every evaluated sample.
// - One increment and one decrement value serve all records.
// - Counters compared with positive and negative permit thresholds; either one reached arms the record.
// - Zero permit threshold arms at once on entering safing state.
// - Counters freeze while compare complete bits stay unread.
// - Each enabled record maps to one internal permit; permits OR their records.
// - Per-loop mask gates each internal permit onto the loop enables.
// - Safing FET rail follows internal permits or external fire enables.
// - Deploy permit pin follows internal arming or external fire enable combination.
// - Pin test and rail test never run together in diagnostic state.
// - Started dwell completes even if record disabled; only sequencer reset cuts it.
// - Pin has own dwell counter loaded with longest dwell of driving records.
// - Dwell counter only loaded when new value exceeds remaining time.
// - Qualified disposal line arms outputs from scrap; timeout returns to scrap.
// - Period and duty checked per cycle; three qualified cycles needed.
// - Two consecutive invalid cycles disqualify the disposal line.
// - Combined pair compares sum on record n, difference on record n+1.
// - Record evaluated on first match only until its complete bit clears.
// - Samples processed only in safing state; sequencer reset clears records.
module safing_engine
  import safing_pkg::*;
#(
  parameter int DWELL_UNIT_CYCLES  = DWELL_UNIT_US / TICK_US,
  parameter int SCRAP_TIMEOUT_TICKS = SCRAP_TIMEOUT_US / TICK_US
) (
  input  wire logic                               I_CLK,
  input  wire logic                               I_RST,
  input  wire logic                               i_SEQUENCER_RESET,
  input  wire logic                               i_DIAG_STATE,
  input  wire logic                               i_SAFING_STATE,
  input  wire logic                               i_SCRAP_STATE,
  input  wire logic                               i_SAMPLE_VALID,
  input  wire logic [safing_pkg::NUM_RECORDS-1:0] i_SAMPLE_MATCH,
  input  wire logic [15:0]                        i_SAMPLE_DATA,
  input  wire logic                               i_EXTERNAL_FIRE_ENABLE_HIGH,
  input  wire logic                               i_EXTERNAL_FIRE_ENABLE_LOW,
  input  wire logic                               i_DISPOSAL_LINE_INPUT,
  output logic                                    o_INTERNAL_PERMIT_A,
  output logic                                    o_INTERNAL_PERMIT_B,
  output logic [safing_pkg::NUM_RECORDS-1:0]      o_LOOP_ENABLE,
  output logic                                    o_DEPLOY_PERMIT_PIN,
  output logic                                    o_SAFING_FET_RAIL,
  input  wire logic [7:0]                         i_AWADDR,
  input  wire logic                               i_AWVALID,
  output logic                                    o_AWREADY,
  input  wire logic [31:0]                        i_WDATA,
  input  wire logic [3:0]                         i_WSTRB,
  input  wire logic                               i_WVALID,
  output logic                                    o_WREADY,
  output logic [1:0]                              o_BRESP,
  output logic                                    o_BVALID,
  input  wire logic                               i_BREADY,
  input  wire logic [7:0]                         i_ARADDR,
  input  wire logic                               i_ARVALID,
  output logic                                    o_ARREADY,
  output logic [31:0]                             o_RDATA,
  output logic [1:0]                              o_RRESP,
  output logic                                    o_RVALID,
  input  wire logic                               i_RREADY
);
  import safing_pkg::*;
  localparam int N = NUM_RECORDS;

  logic [31:0]        global_q, permit_th_q;
  logic [7:0]         loop_mask_q;
  logic [N-1:0]       enable_q;
  logic [31:0]        rec_ctrl_q [N];
  logic [15:0]        data_q [N];
  logic [N-1:0]       cap_q, done_q, eval, arm, active;
  logic [CNT_W-1:0]   pos_q [N];
  logic [CNT_W-1:0]   neg_q [N];
  logic               clr;
  logic               cc_clr;
  logic               us_tick, dwell_tick;
  logic [7:0]         us_cnt_q;
  logic [15:0]        unit_cnt_q;
  logic               permit_a, permit_b, pin_active;
  logic [DWELL_W-1:0] pin_dwell;

  assign clr = i_SEQUENCER_RESET;

  // Microsecond tick and dwell unit tick
  always_ff @(posedge I_CLK) begin
    if (I_RST || us_tick) begin
      us_cnt_q <= '0;
    end else begin
      us_cnt_q <= us_cnt_q + 8'h01;
    end
  end
  assign us_tick = (us_cnt_q == 8'(TICK_CYCLES - 1));

  always_ff @(posedge I_CLK) begin
    if (I_RST || dwell_tick) begin
      unit_cnt_q <= '0;
    end else if (us_tick) begin
      unit_cnt_q <= unit_cnt_q + 16'h0001;
    end
  end
  assign dwell_tick = us_tick && (unit_cnt_q == 16'(DWELL_UNIT_CYCLES - 1));

  // AXI4-Lite write channel
  logic        aw_held_q, w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic [31:0] wmask;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      o_BVALID  <= 1'b0;
      o_BRESP   <= RESP_OKAY;
    end else begin
      if (i_AWVALID && o_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= i_AWADDR;
      end
      if (i_WVALID && o_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q  <= i_WDATA;
        wstrb_q  <= i_WSTRB;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        o_BVALID  <= 1'b1;
        o_BRESP   <= wr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_BVALID && i_BREADY) begin
        o_BVALID <= 1'b0;
      end
    end
  end
  assign o_AWREADY = ~aw_held_q && ~o_BVALID && ~I_RST;
  assign o_WREADY  = ~w_held_q && ~o_BVALID && ~I_RST;
  assign wr_go     = aw_held_q && w_held_q && ~o_BVALID;
  assign wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  function automatic logic wr_mapped(input logic [7:0] a);
    wr_mapped = (a == OFS_GLOBAL) || (a == OFS_PERMIT_TH) || (a == OFS_LOOP_MASK)
             || (a == OFS_ENABLE) || (a[7:4] == OFS_REC_CTRL[7:4] && a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Configuration registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      global_q    <= RST_GLOBAL;
      permit_th_q <= RST_PERMIT_TH;
      loop_mask_q <= RST_LOOP_MASK;
      enable_q    <= '0;
      for (int r = 0; r < N; r++) begin
        rec_ctrl_q[r] <= '0;
      end
    end else if (wr_go) begin
      if (awaddr_q == OFS_ENABLE) begin
        enable_q <= N'(merge({28'h0, enable_q}, wdata_q, wmask));
      end
      if (i_DIAG_STATE) begin
        if (awaddr_q == OFS_GLOBAL) begin
          global_q <= merge(global_q, wdata_q, wmask);
          if (wmask[GL_TEST_PIN] && wdata_q[GL_TEST_PIN]) begin
            global_q[GL_TEST_RAIL] <= 1'b0;
          end
        end
        if (awaddr_q == OFS_PERMIT_TH) begin
          permit_th_q <= merge(permit_th_q, wdata_q, wmask);
        end
        if (awaddr_q == OFS_LOOP_MASK) begin
          loop_mask_q <= 8'(merge({24'h0, loop_mask_q}, wdata_q, wmask));
        end
        for (int r = 0; r < N; r++) begin
          if (awaddr_q == OFS_REC_CTRL + 8'(4 * r)) begin
            rec_ctrl_q[r] <= merge(rec_ctrl_q[r], wdata_q, wmask);
          end
        end
      end
    end
  end

  // AXI4-Lite read channel; reading the complete bits clears them
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    case (i_ARADDR)
      OFS_GLOBAL:    rd_val = global_q;
      OFS_PERMIT_TH: rd_val = permit_th_q;
      OFS_LOOP_MASK: rd_val = {24'h0, loop_mask_q};
      OFS_COMPLETE:  rd_val = {28'h0, cap_q};
      OFS_ENABLE:    rd_val = {28'h0, enable_q};
      OFS_STATUS:    rd_val = {27'h0, o_SAFING_FET_RAIL, o_DEPLOY_PERMIT_PIN,
                               o_INTERNAL_PERMIT_B, o_INTERNAL_PERMIT_A, i_SCRAP_STATE};
      default: begin
        rd_ok = 1'b0;
        for (int r = 0; r < N; r++) begin
          if (i_ARADDR == OFS_REC_CTRL + 8'(4 * r)) begin
            rd_val = rec_ctrl_q[r];
            rd_ok  = 1'b1;
          end
          if (i_ARADDR == OFS_REC_COUNT + 8'(4 * r)) begin
            rd_val = {16'h0, neg_q[r], pos_q[r]};
            rd_ok  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_RVALID <= 1'b0;
      o_RDATA  <= '0;
      o_RRESP  <= RESP_OKAY;
    end else if (i_ARVALID && o_ARREADY) begin
      o_RVALID <= 1'b1;
      o_RDATA  <= rd_val;
      o_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (o_RVALID && i_RREADY) begin
      o_RVALID <= 1'b0;
    end
  end
  assign o_ARREADY = ~o_RVALID && ~I_RST;
  assign cc_clr    = i_ARVALID && o_ARREADY && (i_ARADDR == OFS_COMPLETE);

  // Records: capture, evaluate, count, dwell
  for (genvar r = 0; r < N; r++) begin : g_rec
    localparam int P = r ^ 1;
    logic               comb, accept;
    logic signed [17:0] own, other, value, th;
    logic               ev_pos, ev_neg;

    assign comb   = rec_ctrl_q[r][RC_COMBINE];
    assign accept = i_SAMPLE_VALID && i_SAMPLE_MATCH[r] && i_SAFING_STATE && enable_q[r]
                  && (~cap_q[r] || cc_clr);
    assign eval[r] = cap_q[r] && ~done_q[r] && (~comb || cap_q[P]);
    assign own   = 18'(signed'(data_q[r]));
    assign other = 18'(signed'(data_q[P]));
    assign value = ~comb ? own : ((r % 2 == 0) ? own + other : own - other);
    assign th    = signed'({2'b00, rec_ctrl_q[r][15:0]});
    assign ev_pos = value > th;
    assign ev_neg = value < -th;

    always_ff @(posedge I_CLK) begin
      if (I_RST || clr) begin
        cap_q[r]  <= 1'b0;
        done_q[r] <= 1'b0;
        data_q[r] <= '0;
      end else begin
        if (accept) begin
          cap_q[r]  <= 1'b1;
          data_q[r] <= i_SAMPLE_DATA;
        end else if (cc_clr) begin
          cap_q[r] <= 1'b0;
        end
        if (accept || cc_clr) begin
          done_q[r] <= 1'b0;
        end else if (eval[r]) begin
          done_q[r] <= 1'b1;
        end
      end
    end

    // Counters only move on an evaluation, which needs a freshly captured sample
    always_ff @(posedge I_CLK) begin
      if (I_RST || clr) begin
        pos_q[r] <= '0;
        neg_q[r] <= '0;
      end else if (eval[r] && i_SAFING_STATE) begin
        pos_q[r] <= step(pos_q[r], ev_pos);
        neg_q[r] <= step(neg_q[r], ev_neg);
      end
    end

    assign arm[r] = i_SAFING_STATE && ~clr && enable_q[r]
                  && (pos_q[r] >= permit_th_q[7:0] || neg_q[r] >= permit_th_q[15:8]);

    dwell_stretch #(.W(DWELL_W)) u_dwell (
      .i_clk    (I_CLK),
      .i_rst    (I_RST),
      .i_clear  (clr),
      .i_tick   (dwell_tick),
      .i_arm    (arm[r]),
      .i_value  (rec_ctrl_q[r][RC_DWELL_LSB +: DWELL_W]),
      .o_active (active[r])
    );
  end

  // Saturating counter step with shared increment and decrement
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c, input logic hit);
    logic [CNT_W:0] s;
    s = {1'b0, c} + {1'b0, global_q[GL_INC_LSB +: CNT_W]};
    if (hit) begin
      step = s[CNT_W] ? '1 : s[CNT_W-1:0];
    end else begin
      step = (c > global_q[GL_DEC_LSB +: CNT_W]) ? c - global_q[GL_DEC_LSB +: CNT_W] : '0;
    end
  endfunction

  // Permit OR-ing and longest dwell for the pin
  always_comb begin
    permit_a  = 1'b0;
    permit_b  = 1'b0;
    pin_dwell = '0;
    for (int r = 0; r < N; r++) begin
      if (active[r] && ~rec_ctrl_q[r][RC_MAP]) begin
        permit_a = 1'b1;
      end
      if (active[r] && rec_ctrl_q[r][RC_MAP]) begin
        permit_b = 1'b1;
      end
      if (arm[r] && rec_ctrl_q[r][RC_DWELL_LSB +: DWELL_W] > pin_dwell) begin
        pin_dwell = rec_ctrl_q[r][RC_DWELL_LSB +: DWELL_W];
      end
    end
  end

  dwell_stretch #(.W(DWELL_W)) u_pin_dwell (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_clear  (clr),
    .i_tick   (dwell_tick),
    .i_arm    (|arm),
    .i_value  (pin_dwell),
    .o_active (pin_active)
  );

  // Disposal line qualification
  logic         line_q;
  logic [15:0]  per_cnt_q, high_cnt_q;
  logic [1:0]   good_q, bad_q;
  logic         cyc_end, cyc_ok, stuck;
  logic [31:0]  to_cnt_q;
  scrap_state_t scrap_q;

  assign stuck   = per_cnt_q > 16'(DISP_PERIOD_MAX_US / TICK_US);
  assign cyc_end = (i_DISPOSAL_LINE_INPUT && ~line_q) || (stuck && us_tick);
  assign cyc_ok  = ~stuck && per_cnt_q >= 16'(DISP_PERIOD_MIN_US / TICK_US)
                && high_cnt_q >= 16'(DISP_HIGH_MIN_US / TICK_US)
                && high_cnt_q <= 16'(DISP_HIGH_MAX_US / TICK_US);

  always_ff @(posedge I_CLK) begin
    if (I_RST || ~i_SCRAP_STATE) begin
      line_q     <= 1'b0;
      per_cnt_q  <= '0;
      high_cnt_q <= '0;
      good_q     <= '0;
      bad_q      <= '0;
    end else begin
      line_q <= i_DISPOSAL_LINE_INPUT;
      if (cyc_end) begin
        per_cnt_q  <= '0;
        high_cnt_q <= '0;
        if (cyc_ok) begin
          bad_q <= '0;
          if (good_q != 2'(DISP_GOOD_NEEDED)) begin
            good_q <= good_q + 2'b01;
          end
        end else if (bad_q == 2'(DISP_BAD_LIMIT - 1)) begin
          good_q <= '0;
          bad_q  <= '0;
        end else begin
          bad_q <= bad_q + 2'b01;
        end
      end else if (us_tick) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
        if (i_DISPOSAL_LINE_INPUT) begin
          high_cnt_q <= high_cnt_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST || ~i_SCRAP_STATE) begin
      scrap_q  <= SCRAP_IDLE;
      to_cnt_q <= '0;
    end else begin
      case (scrap_q)
        SCRAP_IDLE: begin
          to_cnt_q <= '0;
          if (good_q == 2'(DISP_GOOD_NEEDED)) begin
            scrap_q <= SCRAP_ARMING;
          end
        end
        SCRAP_ARMING: begin
          if (good_q != 2'(DISP_GOOD_NEEDED)
              || to_cnt_q >= 32'(SCRAP_TIMEOUT_TICKS - 1)) begin
            scrap_q <= SCRAP_IDLE;
          end else if (cyc_end && cyc_ok) begin
            to_cnt_q <= '0;
          end else if (us_tick) begin
            to_cnt_q <= to_cnt_q + 32'h1;
          end
        end
        default: scrap_q <= SCRAP_IDLE;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_INTERNAL_PERMIT_A <= 1'b0;
      o_INTERNAL_PERMIT_B <= 1'b0;
      o_LOOP_ENABLE       <= '0;
      o_DEPLOY_PERMIT_PIN <= 1'b0;
      o_SAFING_FET_RAIL   <= 1'b0;
    end else begin
      o_INTERNAL_PERMIT_A <= permit_a;
      o_INTERNAL_PERMIT_B <= permit_b;
      o_LOOP_ENABLE       <= ({N{permit_a}} & ~loop_mask_q[N-1:0])
                           | ({N{permit_b}} & ~loop_mask_q[2*N-1:N]);
      if (scrap_q == SCRAP_ARMING) begin
        o_DEPLOY_PERMIT_PIN <= 1'b1;
        o_SAFING_FET_RAIL   <= 1'b1;
      end else if (i_DIAG_STATE) begin
        o_DEPLOY_PERMIT_PIN <= global_q[GL_TEST_PIN];
        o_SAFING_FET_RAIL   <= global_q[GL_TEST_RAIL] && ~global_q[GL_TEST_PIN];
      end else begin
        o_DEPLOY_PERMIT_PIN <= global_q[GL_EXT_ENGINE]
                             ? (i_EXTERNAL_FIRE_ENABLE_HIGH && ~i_EXTERNAL_FIRE_ENABLE_LOW)
                             : pin_active;
        o_SAFING_FET_RAIL   <= global_q[GL_EXT_RAIL]
                             ? (i_EXTERNAL_FIRE_ENABLE_HIGH && ~i_EXTERNAL_FIRE_ENABLE_LOW)
                             : (permit_a || permit_b);
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/safing_chk.sv ====
// Port-level assertions for the safing engine
`timescale 1ns/1ps
`default_nettype none
module safing_chk (
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic       i_SEQUENCER_RESET,
  input wire logic       i_DIAG_STATE,
  input wire logic       i_SCRAP_STATE,
  input wire logic       i_EXTERNAL_FIRE_ENABLE_HIGH,
  input wire logic       o_INTERNAL_PERMIT_A,
  input wire logic       o_INTERNAL_PERMIT_B,
  input wire logic [3:0] o_LOOP_ENABLE,
  input wire logic       o_DEPLOY_PERMIT_PIN,
  input wire logic       o_SAFING_FET_RAIL,
  input wire logic       i_AWVALID,
  input wire logic       o_AWREADY,
  input wire logic       i_WVALID,
  input wire logic       o_WREADY,
  input wire logic [1:0] o_BRESP,
  input wire logic       o_BVALID,
  input wire logic       i_BREADY,
  input wire logic       i_ARVALID,
  input wire logic       o_ARREADY,
  input wire logic [31:0] o_RDATA,
  input wire logic       o_RVALID,
  input wire logic       i_RREADY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_wr_taken;
    i_AWVALID && o_AWREADY && i_WVALID && o_WREADY;
  endsequence
  sequence s_rd_taken;
    i_ARVALID && o_ARREADY;
  endsequence
  a_seq_quiet: assert property (i_SEQUENCER_RESET [*3] |->
    !o_INTERNAL_PERMIT_A && !o_INTERNAL_PERMIT_B)
    else $error("permit high under sequencer reset");
  a_loop_from_permit: assert property (o_LOOP_ENABLE != 4'h0 |-> o_INTERNAL_PERMIT_A ||
    o_INTERNAL_PERMIT_B || $past(o_INTERNAL_PERMIT_A) || $past(o_INTERNAL_PERMIT_B))
    else $error("loop enabled without permit");
  a_test_exclusive: assert property (i_DIAG_STATE && !i_SCRAP_STATE && !o_INTERNAL_PERMIT_A &&
    !o_INTERNAL_PERMIT_B && !i_EXTERNAL_FIRE_ENABLE_HIGH |-> !(o_DEPLOY_PERMIT_PIN && o_SAFING_FET_RAIL))
    else $error("pin and rail tests together");
  a_wr_answer: assert property (s_wr_taken |-> ##2 o_BVALID)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_taken |=> o_RVALID)
    else $error("read response late");
  a_bresp_holds: assert property (o_BVALID && !i_BREADY |=> o_BVALID && $stable(o_BRESP))
    else $error("write response dropped");
  a_rdata_holds: assert property (o_RVALID && !i_RREADY |=> o_RVALID && $stable(o_RDATA))
    else $error("read data dropped");
  a_ready_blocked: assert property (o_BVALID |-> !o_AWREADY && !o_WREADY)
    else $error("write taken while response pending");
endmodule
bind safing_engine safing_chk safing_chk_inst (.*);
`default_nettype wire

// ==== sim/sample_src.sv ====
// Sensor sample feed standing in for the monitored sensor traffic
`timescale 1ns/1ps
`default_nettype none
module sample_src (
  input wire logic    i_clk,
  output logic        o_valid,
  output logic [3:0]  o_match,
  output logic [15:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_match = 4'h0;
    o_data = 16'h0000;
  end
  // Data only hold in the pulse cycle; the inverse shows afterwards
  task automatic send(input logic [15:0] v);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_match <= 4'h1;
    o_data <= v;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_match <= 4'h0;
    o_data <= ~v;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the safing engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import safing_pkg::*;
  logic I_CLK = 0, I_RST = 1, i_SEQUENCER_RESET = 0, i_DIAG_STATE = 0, i_SAFING_STATE = 0;
  logic i_SCRAP_STATE = 0, i_DISPOSAL_LINE_INPUT = 0, i_SAMPLE_VALID;
  logic i_EXTERNAL_FIRE_ENABLE_HIGH = 0, i_EXTERNAL_FIRE_ENABLE_LOW = 0;
  logic i_AWVALID = 0, i_WVALID = 0, i_BREADY = 0, i_ARVALID = 0, i_RREADY = 0;
  logic o_INTERNAL_PERMIT_A, o_INTERNAL_PERMIT_B, o_DEPLOY_PERMIT_PIN, o_SAFING_FET_RAIL;
  logic o_AWREADY, o_WREADY, o_BVALID, o_ARREADY, o_RVALID;
  logic [3:0]  i_SAMPLE_MATCH, o_LOOP_ENABLE, i_WSTRB = 4'hf;
  logic [15:0] i_SAMPLE_DATA;
  logic [7:0]  i_AWADDR = 8'h00, i_ARADDR = 8'h00;
  logic [31:0] i_WDATA = 32'h0, o_RDATA, d;
  logic [1:0]  o_BRESP, o_RRESP, r;
  int          errors = 0, checked = 0;
  logic [15:0] sd [6] = '{16'h0014, 16'h0014, 16'hffec, 16'h0005, 16'h000a, 16'hfff5};
  logic [16:0] ec [6] = '{17'h00002, 17'h10004, 17'h00203, 17'h00102, 17'h00001, 17'h00200};
  logic [7:0]  ra [4] = '{OFS_GLOBAL, OFS_PERMIT_TH, OFS_LOOP_MASK, OFS_ENABLE};
  logic [31:0] rv [4] = '{RST_GLOBAL, RST_PERMIT_TH, {24'h0, RST_LOOP_MASK}, 32'h0};
  safing_engine #(.DWELL_UNIT_CYCLES(2), .SCRAP_TIMEOUT_TICKS(50)) safing_engine_inst (.*);
  sample_src sample_src_inst (.i_clk(I_CLK), .o_valid(i_SAMPLE_VALID),
    .o_match(i_SAMPLE_MATCH), .o_data(i_SAMPLE_DATA));
  always #4 I_CLK = ~I_CLK;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    logic pa;
    logic pw;
    pa = 1;
    pw = 1;
    @(posedge I_CLK);
    i_AWADDR <= a;
    i_WDATA <= v;
    i_AWVALID <= 1;
    i_WVALID <= 1;
    while (pa || pw) begin
      @(posedge I_CLK);
      if (pa && o_AWREADY === 1'b1) begin
        pa = 0;
        i_AWVALID <= 0;
      end
      if (pw && o_WREADY === 1'b1) begin
        pw = 0;
        i_WVALID <= 0;
      end
    end
    while (o_BVALID !== 1'b1) @(posedge I_CLK);
    i_BREADY <= 1;
    @(posedge I_CLK);
    s = o_BRESP;
    i_BREADY <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    @(posedge I_CLK);
    i_ARADDR <= a;
    i_ARVALID <= 1;
    do @(posedge I_CLK); while (o_ARREADY !== 1'b1);
    i_ARVALID <= 0;
    do @(posedge I_CLK); while (o_RVALID !== 1'b1);
    i_RREADY <= 1;
    @(posedge I_CLK);
    v = o_RDATA;
    s = o_RRESP;
    i_RREADY <= 0;
  endtask
  task automatic pins(input logic [31:0] e);
    repeat (3) @(posedge I_CLK);
    chk("pins", e, 32'({o_DEPLOY_PERMIT_PIN, o_SAFING_FET_RAIL}));
  endtask
  initial begin
    repeat (20000) @(posedge I_CLK);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge I_CLK);
    I_RST <= 0;
    wr(OFS_GLOBAL, 32'h0000_0102, r);
    rd(OFS_GLOBAL, d, r);
    chk("glob", RST_GLOBAL, d);
    i_DIAG_STATE <= 1;
    wr(OFS_GLOBAL, 32'h0000_0102, r);
    wr(OFS_REC_CTRL, 32'h0000_000a, r);
    wr(OFS_LOOP_MASK, 32'h0000_00f0, r);
    i_DIAG_STATE <= 0;
    wr(OFS_ENABLE, 32'h0000_0001, r);
    i_SAFING_STATE <= 1;
    for (int i = 0; i < 6; i++) begin
      rd(OFS_COMPLETE, d, r);
      sample_src_inst.send(sd[i]);
      rd(OFS_REC_COUNT, d, r);
      chk("cnt", {16'h0, ec[i][15:0]}, d);
      chk("perm", 32'(ec[i][16]), 32'(o_INTERNAL_PERMIT_A));
      chk("loop", 32'({4{ec[i][16]}}), 32'(o_LOOP_ENABLE));
    end
    $display("sample rows done");
    sample_src_inst.send(16'h0014);
    rd(OFS_REC_COUNT, d, r);
    chk("cnt", 32'h0000_0200, d);
    i_SEQUENCER_RESET <= 1;
    repeat (4) @(posedge I_CLK);
    i_SEQUENCER_RESET <= 0;
    rd(OFS_REC_COUNT, d, r);
    chk("cnt", 32'h0, d);
    $display("sequencer reset done");
    i_SAFING_STATE <= 0;
    i_DIAG_STATE <= 1;
    i_EXTERNAL_FIRE_ENABLE_HIGH <= 1;
    wr(OFS_GLOBAL, 32'h0003_0102, r);
    i_DIAG_STATE <= 0;
    pins(32'h3);
    i_EXTERNAL_FIRE_ENABLE_LOW <= 1;
    pins(32'h0);
    i_EXTERNAL_FIRE_ENABLE_HIGH <= 0;
    i_EXTERNAL_FIRE_ENABLE_LOW <= 0;
    i_DIAG_STATE <= 1;
    wr(OFS_GLOBAL, 32'h0008_0102, r);
    pins(32'h1);
    wr(OFS_GLOBAL, 32'h000c_0102, r);
    pins(32'h2);
    $display("pin rail done");
    I_RST <= 1;
    repeat (8) @(posedge I_CLK);
    I_RST <= 0;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], d, r);
      chk("rst", rv[i], d);
    end
    rd(8'hfc, d, r);
    chk("resp", 32'(RESP_SLVERR), 32'(r));
    wr(OFS_STATUS, 32'h0, r);
    chk("resp", 32'(RESP_SLVERR), 32'(r));
    $display("reset values done");
    wr(OFS_PERMIT_TH, 32'h0000_0400, r);
    wr(OFS_REC_CTRL + 8'h04, 32'h0005_0000, r);
    wr(OFS_LOOP_MASK, 32'h0000_005f, r);
    wr(OFS_ENABLE, 32'h0000_0003, r);
    i_DIAG_STATE <= 0;
    i_SAFING_STATE <= 1;
    repeat (4) @(posedge I_CLK);
    chk("perm", 32'h1, 32'(o_INTERNAL_PERMIT_A));
    chk("permb", 32'h1, 32'(o_INTERNAL_PERMIT_B));
    chk("loop", 32'h0000_000a, 32'(o_LOOP_ENABLE));
    $display("zero threshold done");
    wr(OFS_ENABLE, 32'h0, r);
    pins(32'h3);
    chk("perma", 32'h0, 32'(o_INTERNAL_PERMIT_A));
    repeat (600) @(posedge I_CLK);
    pins(32'h0);
    $display("dwell done");
    give_verdict();
  end
endmodule
`default_nettype wire
